// ==== rtl/fspc_pkg.sv ====
package fspc_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] FSPC_ADDR_LOW_OFF = 16'hF0E0;
    localparam logic [15:0] FSPC_ADDR_HIGH_OFF = 16'hF0E1;
    localparam logic [15:0] FSPC_WDATA_LOW_OFF = 16'hF0E2;
    localparam logic [15:0] FSPC_WDATA_HIGH_OFF = 16'hF0E3;
    localparam logic [15:0] FSPC_ERASE_CTRL_OFF = 16'hF0E4;
    localparam logic [15:0] FSPC_UNLOCK_OFF = 16'hF0E5;
    localparam logic [15:0] FSPC_SEGMENT_OFF = 16'hF0E6;
    localparam logic [15:0] FSPC_SELF_EN_OFF = 16'hF0E7;
    localparam logic [15:0] FSPC_REMAP_OFF = 16'hF0EC;
    localparam logic [15:0] FSPC_STATUS_OFF = 16'hF0F0;

    // ----------------------------------------------------------------
    // Values and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] FSPC_RESET_BYTE = 8'h00;
    localparam logic [7:0] FSPC_KEY_FIRST = 8'hFA;
    localparam logic [7:0] FSPC_KEY_SECOND = 8'hF5;
    localparam int FSPC_BLOCK_ERASE_BIT = 0;
    localparam int FSPC_SECTOR_ERASE_BIT = 1;
    localparam int FSPC_SELF_ON_BIT = 0;
    localparam int FSPC_BOOT_REMAP_BIT = 7;
    localparam logic [1:0] FSPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FSPC_RESP_SLVERR = 2'h2;

    // Flash operation kinds
    typedef enum logic [1:0]
    {
        FSPC_OP_NONE = 2'b00,
        FSPC_OP_WORD = 2'b01,
        FSPC_OP_BLOCK = 2'b10,
        FSPC_OP_SECTOR = 2'b11
    } fspc_op_t;

    // Sequencer states
    typedef enum logic [1:0]
    {
        FSPC_ST_IDLE = 2'b00,
        FSPC_ST_REQ = 2'b01,
        FSPC_ST_WAIT = 2'b10
    } fspc_state_t;

    // Request to the flash array
    typedef struct packed
    {
        fspc_op_t op;
        logic [1:0] segment;
        logic [15:0] addr;
        logic [15:0] data;
    } fspc_flash_req_t;

    // Remap settings for the core
    typedef struct packed
    {
        logic boot_area;
        logic [2:0] segment;
        logic [3:0] upper_nibble;
    } fspc_remap_t;

endpackage

// ==== rtl/fspc_ctrl.sv ====
// Function
// - Write word kept as low byte bits 7..0 and high byte bits 15..8.
// - Writing the high data byte launches a one-word program.
// - CPU stalls during one-word program and resumes when done.
// - Erase control is write-only; bit 0 starts block erase.
// - Bit 1 of erase control starts sector erase.
// - Both zero starts nothing; both one starts block erase.
// - Each erase start bit self-clears after its erase completes.
// - CPU stalls during any erase and resumes when done.
// - Erase target comes from segment plus high address byte.
// - Key FA then F5 arms exactly one later erase or write.
// - Arming is used by one operation; repeat keys each time.
// - Unrelated activity between key writes does not break unlock.
// - A value other than F5 or FA after FA discards the first key step.
// - Segment register has a two-bit field; upper bits read zero.
// - Self-program enable bit 0 resets off; upper bits read zero.
// - Remap bits 3..0 give start address bits 15..12 for low 4 KB.
// - Remap bits 6..4 give the segment of the remap target.
// - Remap bit 7 maps boot region onto the dedicated boot area.
// - Remap settings apply on CPU-only break-instruction reset.
// - Block erase uses segment and top two high address bits.
// - Low address bit 0 is fixed zero and ignores writes.
module fspc_ctrl
    import fspc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash array side
    output fspc_flash_req_t flash_req,
    output logic flash_req_valid,
    input wire logic flash_done,
    // Core side
    output logic cpu_stall,
    input wire logic break_reset,
    output fspc_remap_t remap_active
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] addr_low_reg;
    logic [7:0] addr_high_reg;
    logic [7:0] wdata_low_reg;
    logic [7:0] wdata_high_reg;
    logic block_erase_start_reg;
    logic sector_erase_start_reg;
    logic [1:0] segment_reg;
    logic self_program_on_reg;
    logic [7:0] remap_reg;
    logic key_first_reg;
    logic armed_reg;
    fspc_state_t state_reg;
    fspc_state_t state_next;

    // ----------------------------------------------------------------
    // AXI write channel capture
    // ----------------------------------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [15:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;

    // Write commits once address and data are both held
    wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire wr_ok = wr_fire && w_lane_reg;
    wire [15:0] wr_addr = aw_addr_reg;
    wire [7:0] wr_byte = w_byte_reg;
    // Mapped write addresses, needed for the response code
    wire wr_known = (wr_addr == FSPC_ADDR_LOW_OFF) || (wr_addr == FSPC_ADDR_HIGH_OFF)
        || (wr_addr == FSPC_WDATA_LOW_OFF) || (wr_addr == FSPC_WDATA_HIGH_OFF)
        || (wr_addr == FSPC_ERASE_CTRL_OFF) || (wr_addr == FSPC_UNLOCK_OFF)
        || (wr_addr == FSPC_SEGMENT_OFF) || (wr_addr == FSPC_SELF_EN_OFF)
        || (wr_addr == FSPC_REMAP_OFF);

    // Accept address and data independently, respond once both are in
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FSPC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_known && w_lane_reg) ? FSPC_RESP_OKAY : FSPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write decode (register data sits in lane 0 of its word)
    // ----------------------------------------------------------------
    wire we_addr_low = wr_ok && (wr_addr == FSPC_ADDR_LOW_OFF);
    wire we_addr_high = wr_ok && (wr_addr == FSPC_ADDR_HIGH_OFF);
    wire we_wdata_low = wr_ok && (wr_addr == FSPC_WDATA_LOW_OFF);
    wire we_wdata_high = wr_ok && (wr_addr == FSPC_WDATA_HIGH_OFF);
    wire we_erase = wr_ok && (wr_addr == FSPC_ERASE_CTRL_OFF);
    wire we_key = wr_ok && (wr_addr == FSPC_UNLOCK_OFF);
    wire we_segment = wr_ok && (wr_addr == FSPC_SEGMENT_OFF);
    wire we_self = wr_ok && (wr_addr == FSPC_SELF_EN_OFF);
    wire we_remap = wr_ok && (wr_addr == FSPC_REMAP_OFF);

    // Launch only when enabled, armed and idle
    wire allowed = self_program_on_reg && armed_reg && (state_reg == FSPC_ST_IDLE);
    wire go_word = we_wdata_high && allowed;
    wire go_block = we_erase && allowed && wr_byte[FSPC_BLOCK_ERASE_BIT];
    wire go_sector = we_erase && allowed && !wr_byte[FSPC_BLOCK_ERASE_BIT]
        && wr_byte[FSPC_SECTOR_ERASE_BIT];
    wire go_any = go_word || go_block || go_sector;

    // Data, address and configuration registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            addr_low_reg <= FSPC_RESET_BYTE;
            addr_high_reg <= FSPC_RESET_BYTE;
            wdata_low_reg <= FSPC_RESET_BYTE;
            wdata_high_reg <= FSPC_RESET_BYTE;
            segment_reg <= 2'b00;
            self_program_on_reg <= 1'b0;
            remap_reg <= FSPC_RESET_BYTE;
        end
        else
        begin
            if (we_addr_low)
                addr_low_reg <= {wr_byte[7:1], 1'b0};
            if (we_addr_high)
                addr_high_reg <= wr_byte;
            if (we_wdata_low)
                wdata_low_reg <= wr_byte;
            if (we_wdata_high)
                wdata_high_reg <= wr_byte;
            if (we_segment)
                segment_reg <= wr_byte[1:0];
            if (we_self)
                self_program_on_reg <= wr_byte[FSPC_SELF_ON_BIT];
            if (we_remap)
                remap_reg <= wr_byte;
        end
    end

    // Unlock key sequence
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            key_first_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            if (we_key)
            begin
                // Only key writes affect the first step
                key_first_reg <= (wr_byte == FSPC_KEY_FIRST);
                if (key_first_reg && wr_byte == FSPC_KEY_SECOND)
                    armed_reg <= 1'b1;
            end
            else if (go_any)
            begin
                armed_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FSPC_ST_IDLE:
                if (go_any)
                    state_next = FSPC_ST_REQ;
            FSPC_ST_REQ:
                state_next = FSPC_ST_WAIT;
            FSPC_ST_WAIT:
                if (flash_done)
                    state_next = FSPC_ST_IDLE;
            default:
                state_next = FSPC_ST_IDLE;
        endcase
    end

    // Request, stall and start bits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= FSPC_ST_IDLE;
            flash_req <= '0;
            flash_req_valid <= 1'b0;
            cpu_stall <= 1'b0;
            block_erase_start_reg <= 1'b0;
            sector_erase_start_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            flash_req_valid <= (state_next == FSPC_ST_REQ);
            cpu_stall <= (state_next != FSPC_ST_IDLE);
            if (go_any)
            begin
                flash_req.op <= go_word ? FSPC_OP_WORD
                    : (go_block ? FSPC_OP_BLOCK : FSPC_OP_SECTOR);
                flash_req.segment <= segment_reg;
                flash_req.addr <= go_block ? {addr_high_reg[7:6], 14'h0000}
                    : {addr_high_reg, go_word ? addr_low_reg : 8'h00};
                flash_req.data <= {wr_byte, wdata_low_reg};
            end
            block_erase_start_reg <= go_block
                || (block_erase_start_reg && !(state_reg == FSPC_ST_WAIT && flash_done));
            sector_erase_start_reg <= go_sector
                || (sector_erase_start_reg && !(state_reg == FSPC_ST_WAIT && flash_done));
        end
    end

    // Remap applied on CPU-only break reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            remap_active <= '0;
        else if (break_reset)
            remap_active <= {remap_reg[FSPC_BOOT_REMAP_BIT], remap_reg[6:4],
                remap_reg[3:0]};
    end

    // ----------------------------------------------------------------
    // AXI read channel
    // ----------------------------------------------------------------
    wire [7:0] status_byte = {5'h00, sector_erase_start_reg, block_erase_start_reg, armed_reg};
    wire rd_hit = (s_axi_araddr == FSPC_ADDR_LOW_OFF) || (s_axi_araddr == FSPC_ADDR_HIGH_OFF)
        || (s_axi_araddr == FSPC_WDATA_LOW_OFF) || (s_axi_araddr == FSPC_WDATA_HIGH_OFF)
        || (s_axi_araddr == FSPC_SEGMENT_OFF) || (s_axi_araddr == FSPC_SELF_EN_OFF)
        || (s_axi_araddr == FSPC_REMAP_OFF) || (s_axi_araddr == FSPC_STATUS_OFF);
    // Write-only registers read zero
    wire [7:0] rd_byte =
        (s_axi_araddr == FSPC_ADDR_LOW_OFF) ? addr_low_reg :
        (s_axi_araddr == FSPC_ADDR_HIGH_OFF) ? addr_high_reg :
        (s_axi_araddr == FSPC_WDATA_LOW_OFF) ? wdata_low_reg :
        (s_axi_araddr == FSPC_WDATA_HIGH_OFF) ? wdata_high_reg :
        (s_axi_araddr == FSPC_SEGMENT_OFF) ? {6'h00, segment_reg} :
        (s_axi_araddr == FSPC_SELF_EN_OFF) ? {7'h00, self_program_on_reg} :
        (s_axi_araddr == FSPC_REMAP_OFF) ? remap_reg :
        (s_axi_araddr == FSPC_STATUS_OFF) ? status_byte : 8'h00;

    // One-cycle address accept, data the following cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= FSPC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? FSPC_RESP_OKAY : FSPC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    unlock_needed_a: assert property (@(posedge clk) disable iff (sys_rst)
        (we_wdata_high && !(self_program_on_reg && armed_reg) && state_reg == FSPC_ST_IDLE)
        |=> !cpu_stall)
        else $error("operation started without unlock");
    arm_consumed_a: assert property (@(posedge clk) disable iff (sys_rst)
        (go_any && !we_key) |=> !armed_reg)
        else $error("arming not consumed");
    key_arms_a: assert property (@(posedge clk) disable iff (sys_rst)
        (we_key && key_first_reg && wr_byte == FSPC_KEY_SECOND) |=> armed_reg)
        else $error("key sequence did not arm");
    bad_key_a: assert property (@(posedge clk) disable iff (sys_rst)
        (we_key && wr_byte != FSPC_KEY_FIRST) |=> !key_first_reg)
        else $error("first key step kept");
    stall_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
        go_any |=> cpu_stall && flash_req_valid ##1 !flash_req_valid)
        else $error("no stall after launch");
    stall_ends_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == FSPC_ST_WAIT && flash_done) |=> !cpu_stall)
        else $error("stall held after done");
    start_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == FSPC_ST_WAIT && flash_done) |=> !block_erase_start_reg
        && !sector_erase_start_reg)
        else $error("erase start bit not cleared");
    block_bit_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        go_block |=> block_erase_start_reg && !sector_erase_start_reg)
        else $error("block erase start bit not set");
    sector_bit_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        go_sector |=> sector_erase_start_reg && !block_erase_start_reg)
        else $error("sector erase start bit not set");
    both_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        (go_any && we_erase && wr_byte[1:0] == 2'b11) |=> flash_req.op == FSPC_OP_BLOCK)
        else $error("both bits did not pick block erase");
    addr_even_a: assert property (@(posedge clk) disable iff (sys_rst)
        addr_low_reg[0] == 1'b0)
        else $error("low address bit 0 set");
    word_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        go_word |=> flash_req.data == {wdata_high_reg, wdata_low_reg})
        else $error("word data mismatch");
    remap_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        break_reset |=> remap_active == $past(remap_reg))
        else $error("remap settings not applied on break reset");

endmodule

// ==== bench/fspc_flash_model.sv ====
module fspc_flash_model
    import fspc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Requests from the sequencer and the bench's done delay
    input wire fspc_flash_req_t flash_req,
    input wire logic flash_req_valid,
    input wire logic [7:0] done_delay,
    // Completion and record
    output logic flash_done,
    output fspc_flash_req_t last_req,
    output logic [7:0] op_count
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_reg;
    logic busy_reg;

    // Array busy for a settable time, then a one-cycle done pulse
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            flash_done <= 1'b0;
            last_req <= '0;
            op_count <= 8'h00;
        end
        else
        begin
            flash_done <= 1'b0;
            if (flash_req_valid)
            begin
                busy_reg <= 1'b1;
                cnt_reg <= done_delay;
                last_req <= flash_req;
                op_count <= op_count + 8'h01;
            end
            else if (busy_reg && cnt_reg == 8'h00)
            begin
                flash_done <= 1'b1;
                busy_reg <= 1'b0;
            end
            else if (busy_reg)
            begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

// ==== bench/flash_self_program_ctrl_bench.sv ====
module flash_self_program_ctrl_bench;
    import fspc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] awaddr = 16'h0000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic [15:0] araddr = 16'h0000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    fspc_flash_req_t flash_req;
    fspc_flash_req_t last_req;
    fspc_remap_t remap_active;
    logic flash_req_valid;
    logic flash_done;
    logic cpu_stall;
    logic break_reset = 1'b0;
    logic [7:0] done_delay = 8'h1E;
    logic [7:0] op_count;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int stall_total = 0;
    int stall_mark = 0;
    logic [15:0] init_map [8] = '{FSPC_ADDR_LOW_OFF, FSPC_ADDR_HIGH_OFF, FSPC_WDATA_LOW_OFF,
        FSPC_WDATA_HIGH_OFF, FSPC_SEGMENT_OFF, FSPC_SELF_EN_OFF, FSPC_REMAP_OFF, FSPC_STATUS_OFF};

    fspc_ctrl i_fspc_ctrl (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .flash_req(flash_req), .flash_req_valid(flash_req_valid),
        .flash_done(flash_done), .cpu_stall(cpu_stall), .break_reset(break_reset),
        .remap_active(remap_active));

    fspc_flash_model i_fspc_flash_model (.clk(clk), .sys_rst(sys_rst), .flash_req(flash_req),
        .flash_req_valid(flash_req_valid), .done_delay(done_delay), .flash_done(flash_done),
        .last_req(last_req), .op_count(op_count));

    // Clock and hang guard
    initial
    begin
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cpu_stall === 1'b1) stall_total <= stall_total + 1;
        if (cycles == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                chk(40'(bresp), 40'(er));
                break;
            end
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                chk(40'(rdata), 40'(d));
                chk(40'(rresp), 40'(er));
                break;
            end
        end
    endtask

    // Unlock pair
    task automatic keys();
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_FIRST, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_SECOND, 4'h1, FSPC_RESP_OKAY);
    endtask

    // Waits out any stall, then checks launch count, kind and address
    task automatic opck(input logic [7:0] cnt, input fspc_op_t op, input logic [15:0] ad,
        input logic stall_exp);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (cpu_stall === 1'b1 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        // Whole stall since the last check, however late this task starts
        n = stall_total - stall_mark;
        stall_mark = stall_total;
        chk(40'(n > int'(done_delay)), 40'(stall_exp));
        chk(40'(n == 0), 40'(!stall_exp));
        chk(40'(op_count), 40'(cnt));
        if (stall_exp)
        begin
            chk(40'({last_req.op, last_req.addr}), 40'({op, ad}));
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, write-only and unmapped places
        foreach (init_map[i]) rd(init_map[i], 8'h00, FSPC_RESP_OKAY);
        rd(FSPC_ERASE_CTRL_OFF, 8'h00, FSPC_RESP_SLVERR);
        rd(FSPC_UNLOCK_OFF, 8'h00, FSPC_RESP_SLVERR);
        rd(16'hF0E8, 8'h00, FSPC_RESP_SLVERR);
        wr(16'hF0E8, 8'h55, 4'h1, FSPC_RESP_SLVERR);
        // Field widths and fixed bits
        wr(FSPC_SEGMENT_OFF, 8'hFF, 4'h1, FSPC_RESP_OKAY);
        rd(FSPC_SEGMENT_OFF, 8'h03, FSPC_RESP_OKAY);
        wr(FSPC_SELF_EN_OFF, 8'hFF, 4'h1, FSPC_RESP_OKAY);
        rd(FSPC_SELF_EN_OFF, 8'h01, FSPC_RESP_OKAY);
        wr(FSPC_ADDR_LOW_OFF, 8'hFF, 4'h1, FSPC_RESP_OKAY);
        rd(FSPC_ADDR_LOW_OFF, 8'hFE, FSPC_RESP_OKAY);
        wr(FSPC_SEGMENT_OFF, 8'h00, 4'h0, FSPC_RESP_SLVERR);
        rd(FSPC_SEGMENT_OFF, 8'h03, FSPC_RESP_OKAY);
        // Disabled, then all-zero erase control
        wr(FSPC_SELF_EN_OFF, 8'h00, 4'h1, FSPC_RESP_OKAY);
        keys();
        wr(FSPC_WDATA_HIGH_OFF, 8'h11, 4'h1, FSPC_RESP_OKAY);
        opck(8'h00, FSPC_OP_NONE, 16'h0000, 1'b0);
        wr(FSPC_SELF_EN_OFF, 8'h01, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_ERASE_CTRL_OFF, 8'h00, 4'h1, FSPC_RESP_OKAY);
        opck(8'h00, FSPC_OP_NONE, 16'h0000, 1'b0);
        // Block erase, keys split by other writes, both start bits set
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_FIRST, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_SEGMENT_OFF, 8'h01, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_ADDR_HIGH_OFF, 8'hC5, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_SECOND, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_ERASE_CTRL_OFF, 8'h03, 4'h1, FSPC_RESP_OKAY);
        rd(FSPC_STATUS_OFF, 8'h02, FSPC_RESP_OKAY);
        opck(8'h01, FSPC_OP_BLOCK, 16'hC000, 1'b1);
        chk(40'(last_req.segment), 40'h1);
        rd(FSPC_STATUS_OFF, 8'h00, FSPC_RESP_OKAY);
        // Arming used up, then a broken key pair
        wr(FSPC_ERASE_CTRL_OFF, 8'h02, 4'h1, FSPC_RESP_OKAY);
        opck(8'h01, FSPC_OP_NONE, 16'h0000, 1'b0);
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_FIRST, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_UNLOCK_OFF, 8'h12, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_UNLOCK_OFF, FSPC_KEY_SECOND, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_ERASE_CTRL_OFF, 8'h02, 4'h1, FSPC_RESP_OKAY);
        opck(8'h01, FSPC_OP_NONE, 16'h0000, 1'b0);
        // Sector erase of the word target, prompt array
        done_delay <= 8'h00;
        keys();
        wr(FSPC_ADDR_HIGH_OFF, 8'h12, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_ERASE_CTRL_OFF, 8'h02, 4'h1, FSPC_RESP_OKAY);
        opck(8'h02, FSPC_OP_SECTOR, 16'h1200, 1'b1);
        chk(40'(last_req.segment), 40'h1);
        // One-word write, low byte first
        keys();
        wr(FSPC_ADDR_LOW_OFF, 8'h35, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_WDATA_LOW_OFF, 8'hCD, 4'h1, FSPC_RESP_OKAY);
        wr(FSPC_WDATA_HIGH_OFF, 8'hAB, 4'h1, FSPC_RESP_OKAY);
        opck(8'h03, FSPC_OP_WORD, 16'h1234, 1'b1);
        chk(40'(last_req.data), 40'hABCD);
        rd(FSPC_WDATA_LOW_OFF, 8'hCD, FSPC_RESP_OKAY);
        rd(FSPC_WDATA_HIGH_OFF, 8'hAB, FSPC_RESP_OKAY);
        // Remap applies only on the break reset
        wr(FSPC_REMAP_OFF, 8'hA7, 4'h1, FSPC_RESP_OKAY);
        rd(FSPC_REMAP_OFF, 8'hA7, FSPC_RESP_OKAY);
        chk(40'(remap_active), 40'h00);
        break_reset <= 1'b1;
        @(posedge clk);
        break_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk(40'(remap_active), 40'hA7);
        end_of_test();
    end
endmodule
